// *** core/prde_ring_host.sv ***
// driver-side engine that offers descriptors into a packed ring and collects used ones
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module prde_ring_host (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [prde_pkg::PRDE_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // shared ring memory, one descriptor per access
   output logic ring_req,
   output logic ring_we,
   output logic [prde_pkg::PRDE_IDX_W-1:0] ring_slot,
   output logic [prde_pkg::PRDE_DESC_W-1:0] ring_wdata,
   input wire logic ring_ack,
   input wire logic [prde_pkg::PRDE_DESC_W-1:0] ring_rdata,
   // available buffer notification
   output logic avail_notify
);
   import prde_pkg::*;

   prde_reg_if rif ();

   prde_apb_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rif(rif)
   );

   prde_state_t state_q, state_d;
   logic req_q, we_q, notify_q, used_valid_q, used_wr_q;
   logic [PRDE_IDX_W-1:0] slot_q;
   logic [PRDE_DESC_W-1:0] wdata_q;
   logic [PRDE_CNT_W-1:0] out_q;
   logic [15:0] used_id_q;
   logic [31:0] used_len_q;
   logic [PRDE_IDX_W-1:0] a_idx, u_idx;
   logic a_wrap, u_wrap;

   wire st_idle = state_q == PRDE_S_IDLE;
   wire st_post = state_q == PRDE_S_POST;
   wire st_poll = state_q == PRDE_S_POLL;
   wire qsize_ok = (rif.qsize != 16'h0000) && (rif.qsize <= PRDE_QSIZE_MAX);
   wire full = out_q >= rif.qsize;
   wire clr = rif.ring_clr && st_idle;
   wire start_post = st_idle && rif.enable && !clr && qsize_ok && rif.post_req && !full;
   wire start_poll = st_idle && rif.enable && !clr && qsize_ok && !start_post
      && !used_valid_q && (out_q != '0);
   wire post_ack = st_post && ring_ack;
   wire poll_ack = st_poll && ring_ack;
   wire [15:0] rd_flags = ring_rdata[PRDE_D_FL_LSB +: 16];
   wire rd_used = prde_is_used(rd_flags, u_wrap);
   wire got_used = poll_ack && rd_used;
   wire rd_wr = rd_flags[PRDE_FL_WRITE];

   // a group completion covers n slots; zero counts as one, never past what is out
   wire [15:0] n_raw = (rif.consume_n == 16'h0000) ? 16'h0001 : rif.consume_n;
   wire [15:0] n_eff = (n_raw > out_q) ? out_q : n_raw;
   wire do_consume = rif.consume && used_valid_q && !clr;
   wire [PRDE_CNT_W-1:0] out_inc = post_ack ? 16'h0001 : 16'h0000;
   wire [PRDE_CNT_W-1:0] out_dec = do_consume ? n_eff : 16'h0000;

   // offered descriptor: address, length, id and flags packed at their fields
   wire [PRDE_DESC_W-1:0] offer = {prde_avail_flags(rif.d_flags, a_wrap), rif.d_id,
      rif.d_len, rif.d_addr};

   prde_ring_ptr u_avail (
      .pclk(pclk),
      .presetn(presetn),
      .clr(clr),
      .adv(post_ack),
      .step(16'h0001),
      .qsize(rif.qsize),
      .idx(a_idx),
      .wrap(a_wrap)
   );

   prde_ring_ptr u_used (
      .pclk(pclk),
      .presetn(presetn),
      .clr(clr),
      .adv(do_consume),
      .step(n_eff),
      .qsize(rif.qsize),
      .idx(u_idx),
      .wrap(u_wrap)
   );

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PRDE_S_IDLE: begin
            if (start_post) state_d = PRDE_S_POST;
            else if (start_poll) state_d = PRDE_S_POLL;
         end
         PRDE_S_POST: begin
            if (ring_ack) state_d = PRDE_S_IDLE;
         end
         PRDE_S_POLL: begin
            if (ring_ack) state_d = PRDE_S_IDLE;
         end
         default: state_d = PRDE_S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= PRDE_S_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         slot_q <= '0;
         wdata_q <= '0;
      end else begin
         state_q <= state_d;
         if (start_post || start_poll) begin
            req_q <= 1'b1;
            we_q <= start_post;
            slot_q <= start_post ? a_idx : u_idx;
            wdata_q <= start_post ? offer : wdata_q;
         end else if (ring_ack) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '0;
         notify_q <= 1'b0;
      end else begin
         out_q <= clr ? '0 : out_q + out_inc - out_dec;
         notify_q <= post_ack;
      end
   end

   // a newly found used entry wins over a consume in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         used_valid_q <= 1'b0;
         used_wr_q <= 1'b0;
         used_id_q <= 16'h0000;
         used_len_q <= 32'h00000000;
      end else begin
         used_valid_q <= got_used || (used_valid_q && !do_consume && !clr);
         if (got_used) begin
            used_id_q <= ring_rdata[PRDE_D_ID_LSB +: 16];
            used_wr_q <= rd_wr;
            used_len_q <= rd_wr ? ring_rdata[PRDE_D_LEN_LSB +: 32] : 32'h00000000;
         end
      end
   end

   assign ring_req = req_q;
   assign ring_we = we_q;
   assign ring_slot = slot_q;
   assign ring_wdata = wdata_q;
   assign avail_notify = notify_q;
   assign rif.post_done = post_ack;
   assign rif.full = full;
   assign rif.qsize_err = !qsize_ok;
   assign rif.used_valid = used_valid_q;
   assign rif.used_id = used_id_q;
   assign rif.used_wr = used_wr_q;
   assign rif.used_len = used_len_q;
   assign rif.avail_wrap = a_wrap;
   assign rif.used_wrap = u_wrap;
   assign rif.outstanding = out_q;
   assign rif.avail_idx = a_idx;
   assign rif.used_idx = u_idx;

   property p_offer_flags;
      @(posedge pclk) disable iff (!presetn)
      (ring_req && ring_we) |-> (ring_wdata[PRDE_D_FL_LSB + PRDE_FL_AVAIL] == a_wrap)
         && (ring_wdata[PRDE_D_FL_LSB + PRDE_FL_USED] != a_wrap);
   endproperty
   a_offer_flags: assert property (p_offer_flags) else $error("offer indicators wrong");

   property p_no_overfill;
      @(posedge pclk) disable iff (!presetn)
      start_post |-> (out_q < rif.qsize) && (rif.qsize <= PRDE_QSIZE_MAX);
   endproperty
   a_no_overfill: assert property (p_no_overfill) else $error("offer into a full ring");

   property p_req_hold;
      @(posedge pclk) disable iff (!presetn)
      (ring_req && !ring_ack) |=> ring_req && $stable(ring_slot) && $stable(ring_we)
         && $stable(ring_wdata);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("ring request dropped early");

   property p_post_slot;
      @(posedge pclk) disable iff (!presetn)
      start_post |=> ring_req && ring_we && (ring_slot == $past(a_idx));
   endproperty
   a_post_slot: assert property (p_post_slot) else $error("offer not at the next slot");

   property p_post_count;
      @(posedge pclk) disable iff (!presetn)
      (post_ack && !do_consume && !clr) |=> (out_q == $past(out_q) + 16'h0001) ##0 avail_notify;
   endproperty
   a_post_count: assert property (p_post_count) else $error("offer not counted or notified");

   property p_used_seen;
      @(posedge pclk) disable iff (!presetn)
      (poll_ack && !used_valid_q) |=> (used_valid_q == $past(rd_used))
         && (!used_valid_q || used_id_q == $past(ring_rdata[PRDE_D_ID_LSB +: 16]));
   endproperty
   a_used_seen: assert property (p_used_seen) else $error("used entry missed or wrong id");

   property p_len_mask;
      @(posedge pclk) disable iff (!presetn)
      (used_valid_q && !used_wr_q) |-> (used_len_q == 32'h00000000);
   endproperty
   a_len_mask: assert property (p_len_mask) else $error("length kept without write flag");

   property p_skip;
      @(posedge pclk) disable iff (!presetn)
      (do_consume && !post_ack) |=> !used_valid_q && (out_q == $past(out_q) - $past(n_eff));
   endproperty
   a_skip: assert property (p_skip) else $error("group skip miscounted");

   property p_no_poll_pending;
      @(posedge pclk) disable iff (!presetn)
      used_valid_q |-> !(ring_req && !ring_we);
   endproperty
   a_no_poll_pending: assert property (p_no_poll_pending) else $error("poll while pending");

   property p_poll_slot;
      @(posedge pclk) disable iff (!presetn)
      start_poll |=> ring_req && !ring_we && (ring_slot == $past(u_idx));
   endproperty
   a_poll_slot: assert property (p_poll_slot) else $error("poll not at the next slot");

   // every access leaves at least one idle cycle before the next request
   property p_req_gap;
      @(posedge pclk) disable iff (!presetn)
      (ring_req && ring_ack) |=> !ring_req;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("ring request not released");

   // an invalid ring size stalls the engine
   property p_size_stall;
      @(posedge pclk) disable iff (!presetn)
      (!qsize_ok && !ring_req) |=> !ring_req;
   endproperty
   a_size_stall: assert property (p_size_stall) else $error("access with bad ring size");

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      clr |=> (out_q == '0) && !used_valid_q && (a_wrap == PRDE_WRAP_RST)
         && (u_wrap == PRDE_WRAP_RST);
   endproperty
   a_restart: assert property (p_restart) else $error("restart left state behind");

   property p_len_keep;
      @(posedge pclk) disable iff (!presetn)
      (got_used && rd_wr) |=> used_wr_q
         && (used_len_q == $past(ring_rdata[PRDE_D_LEN_LSB +: 32]));
   endproperty
   a_len_keep: assert property (p_len_keep) else $error("used length lost");
endmodule
`default_nettype wire

// *** core/prde_pkg.sv ***
// constants, types and decode helpers of the packed ring host engine
package prde_pkg;

   // apb register map, byte offsets
   localparam int unsigned PRDE_APB_AW = 8;
   localparam logic [7:0] PRDE_OFF_CTRL = 8'h00;
   localparam logic [7:0] PRDE_OFF_QSIZE = 8'h04;
   localparam logic [7:0] PRDE_OFF_DADDR_LO = 8'h08;
   localparam logic [7:0] PRDE_OFF_DADDR_HI = 8'h0C;
   localparam logic [7:0] PRDE_OFF_DLEN = 8'h10;
   localparam logic [7:0] PRDE_OFF_DIDFL = 8'h14;
   localparam logic [7:0] PRDE_OFF_POST = 8'h18;
   localparam logic [7:0] PRDE_OFF_STATUS = 8'h1C;
   localparam logic [7:0] PRDE_OFF_USED_ID = 8'h20;
   localparam logic [7:0] PRDE_OFF_USED_LEN = 8'h24;
   localparam logic [7:0] PRDE_OFF_CONSUME = 8'h28;
   localparam logic [7:0] PRDE_OFF_INDEX = 8'h2C;

   // register field positions
   localparam int unsigned PRDE_CTRL_EN = 0;
   localparam int unsigned PRDE_CTRL_CLR = 1;
   localparam int unsigned PRDE_DIDFL_FL_LSB = 16;
   localparam int unsigned PRDE_ST_BUSY = 0;
   localparam int unsigned PRDE_ST_FULL = 1;
   localparam int unsigned PRDE_ST_USED = 2;
   localparam int unsigned PRDE_ST_AWRAP = 3;
   localparam int unsigned PRDE_ST_UWRAP = 4;
   localparam int unsigned PRDE_ST_QERR = 5;
   localparam int unsigned PRDE_ST_CNT_LSB = 16;
   localparam int unsigned PRDE_USED_WR_BIT = 16;
   localparam int unsigned PRDE_IDX_HI_LSB = 16;

   // ring geometry
   localparam int unsigned PRDE_IDX_W = 15;
   localparam int unsigned PRDE_CNT_W = 16;
   localparam logic [15:0] PRDE_QSIZE_MAX = 16'h8000;
   localparam logic [15:0] PRDE_QSIZE_RST = 16'h0100;
   localparam logic PRDE_WRAP_RST = 1'b1;

   // descriptor layout: addr, len, id, flags from the low end
   localparam int unsigned PRDE_DESC_W = 128;
   localparam int unsigned PRDE_D_ADDR_LSB = 0;
   localparam int unsigned PRDE_D_LEN_LSB = 64;
   localparam int unsigned PRDE_D_ID_LSB = 96;
   localparam int unsigned PRDE_D_FL_LSB = 112;

   // descriptor flag bits
   localparam int unsigned PRDE_FL_NEXT = 0;
   localparam int unsigned PRDE_FL_WRITE = 1;
   localparam int unsigned PRDE_FL_INDIRECT = 2;
   localparam int unsigned PRDE_FL_AVAIL = 7;
   localparam int unsigned PRDE_FL_USED = 15;

   typedef enum logic [2:0] {
      PRDE_S_IDLE = 3'b001,
      PRDE_S_POST = 3'b010,
      PRDE_S_POLL = 3'b100
   } prde_state_t;

   // flags word of an offered descriptor
   function automatic logic [15:0] prde_avail_flags(input logic [2:0] fl, input logic wrap);
      logic [15:0] f;
      f = 16'h0000;
      f[PRDE_FL_NEXT] = fl[PRDE_FL_NEXT];
      f[PRDE_FL_WRITE] = fl[PRDE_FL_WRITE];
      f[PRDE_FL_INDIRECT] = fl[PRDE_FL_INDIRECT];
      f[PRDE_FL_AVAIL] = wrap;
      f[PRDE_FL_USED] = ~wrap;
      return f;
   endfunction

   // slot counts as used when both indicators equal the expected wrap
   function automatic logic prde_is_used(input logic [15:0] f, input logic wrap);
      return (f[PRDE_FL_AVAIL] == wrap) && (f[PRDE_FL_USED] == wrap);
   endfunction

endpackage

// *** core/prde_reg_if.sv ***
// orders and status between the register file and the ring engine
`timescale 1ns/1ps
`default_nettype none
interface prde_reg_if;
   logic enable;
   logic ring_clr;
   logic [15:0] qsize;
   logic [63:0] d_addr;
   logic [31:0] d_len;
   logic [15:0] d_id;
   logic [2:0] d_flags;
   logic post_req;
   logic post_done;
   logic consume;
   logic [15:0] consume_n;
   logic full;
   logic qsize_err;
   logic used_valid;
   logic [15:0] used_id;
   logic used_wr;
   logic [31:0] used_len;
   logic avail_wrap;
   logic used_wrap;
   logic [15:0] outstanding;
   logic [14:0] avail_idx;
   logic [14:0] used_idx;

   modport regs (
      output enable, ring_clr, qsize, d_addr, d_len, d_id, d_flags, post_req, consume, consume_n,
      input post_done, full, qsize_err, used_valid, used_id, used_wr, used_len, avail_wrap,
      input used_wrap, outstanding, avail_idx, used_idx
   );
   modport core (
      input enable, ring_clr, qsize, d_addr, d_len, d_id, d_flags, post_req, consume, consume_n,
      output post_done, full, qsize_err, used_valid, used_id, used_wr, used_len, avail_wrap,
      output used_wrap, outstanding, avail_idx, used_idx
   );
endinterface
`default_nettype wire

// *** core/prde_ring_ptr.sv ***
// circular ring position with its one-bit wrap counter
`timescale 1ns/1ps
`default_nettype none
module prde_ring_ptr (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic clr,
   input wire logic adv,
   input wire logic [15:0] step,
   input wire logic [15:0] qsize,
   // position
   output logic [prde_pkg::PRDE_IDX_W-1:0] idx,
   output logic wrap
);
   import prde_pkg::*;

   logic [PRDE_IDX_W-1:0] idx_q, idx_d;
   logic wrap_q, wrap_d;
   wire [16:0] sum = {2'b00, idx_q} + {1'b0, step};
   wire wrap_hit = sum >= {1'b0, qsize};
   wire [16:0] sum_wr = sum - {1'b0, qsize};

   // past the last slot the position wraps to the sum less qsize and the counter flips
   assign idx_d = clr ? '0 : (adv ? (wrap_hit ? sum_wr[PRDE_IDX_W-1:0] : sum[PRDE_IDX_W-1:0])
                                  : idx_q);
   assign wrap_d = clr ? PRDE_WRAP_RST : ((adv && wrap_hit) ? ~wrap_q : wrap_q);
   assign idx = idx_q;
   assign wrap = wrap_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= '0;
         wrap_q <= PRDE_WRAP_RST;
      end else begin
         idx_q <= idx_d;
         wrap_q <= wrap_d;
      end
   end

   property p_step_idx;
      @(posedge pclk) disable iff (!presetn)
      (adv && !clr && !wrap_hit) |=> (idx == $past(sum[PRDE_IDX_W-1:0]))
         && (wrap == $past(wrap));
   endproperty
   a_step_idx: assert property (p_step_idx) else $error("position out of order");

   property p_wrap_flip;
      @(posedge pclk) disable iff (!presetn)
      (adv && !clr && wrap_hit) |=> (wrap != $past(wrap))
         && (idx == $past(sum_wr[PRDE_IDX_W-1:0]));
   endproperty
   a_wrap_flip: assert property (p_wrap_flip) else $error("wrap not flipped at ring end");

   property p_clr_init;
      @(posedge pclk) disable iff (!presetn)
      clr |=> (wrap == PRDE_WRAP_RST) && (idx == '0);
   endproperty
   a_clr_init: assert property (p_clr_init) else $error("restart left wrap off");
endmodule
`default_nettype wire

// *** core/prde_apb_regs.sv ***
// apb register file of the packed ring host engine
`timescale 1ns/1ps
`default_nettype none
module prde_apb_regs (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [prde_pkg::PRDE_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // engine side
   prde_reg_if.regs rif
);
   import prde_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   logic en_q, clr_q, post_q, cons_q;
   logic [15:0] qsize_q, cons_n_q;
   logic [31:0] alo_q, ahi_q, len_q, idfl_q, prdata_q;

   wire wr = psel && penable && pwrite;
   wire rd_setup = psel && !penable && !pwrite;
   wire mapped = hit(paddr, PRDE_OFF_CTRL) || hit(paddr, PRDE_OFF_QSIZE)
      || hit(paddr, PRDE_OFF_DADDR_LO) || hit(paddr, PRDE_OFF_DADDR_HI)
      || hit(paddr, PRDE_OFF_DLEN) || hit(paddr, PRDE_OFF_DIDFL)
      || hit(paddr, PRDE_OFF_POST) || hit(paddr, PRDE_OFF_STATUS)
      || hit(paddr, PRDE_OFF_USED_ID) || hit(paddr, PRDE_OFF_USED_LEN)
      || hit(paddr, PRDE_OFF_CONSUME) || hit(paddr, PRDE_OFF_INDEX);
   wire wr_ok = wr && mapped;

   wire [31:0] status = {rif.outstanding, 10'h000, rif.qsize_err, rif.used_wrap,
      rif.avail_wrap, rif.used_valid, rif.full, post_q};
   wire [31:0] rd_mux =
      hit(paddr, PRDE_OFF_CTRL) ? {31'h00000000, en_q} :
      hit(paddr, PRDE_OFF_QSIZE) ? {16'h0000, qsize_q} :
      hit(paddr, PRDE_OFF_DADDR_LO) ? alo_q :
      hit(paddr, PRDE_OFF_DADDR_HI) ? ahi_q :
      hit(paddr, PRDE_OFF_DLEN) ? len_q :
      hit(paddr, PRDE_OFF_DIDFL) ? idfl_q :
      hit(paddr, PRDE_OFF_STATUS) ? status :
      hit(paddr, PRDE_OFF_USED_ID) ? {15'h0000, rif.used_wr, rif.used_id} :
      hit(paddr, PRDE_OFF_USED_LEN) ? rif.used_len :
      hit(paddr, PRDE_OFF_INDEX) ? {1'b0, rif.used_idx, 1'b0, rif.avail_idx} :
      32'h00000000;

   // a new post wins over the completion of the previous one
   wire post_d = (wr_ok && hit(paddr, PRDE_OFF_POST)) || (post_q && !rif.post_done);

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;
   assign rif.enable = en_q;
   assign rif.ring_clr = clr_q;
   assign rif.qsize = qsize_q;
   assign rif.d_addr = {ahi_q, alo_q};
   assign rif.d_len = len_q;
   assign rif.d_id = idfl_q[15:0];
   assign rif.d_flags = idfl_q[PRDE_DIDFL_FL_LSB +: 3];
   assign rif.post_req = post_q;
   assign rif.consume = cons_q;
   assign rif.consume_n = cons_n_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         clr_q <= 1'b0;
         post_q <= 1'b0;
         cons_q <= 1'b0;
         qsize_q <= PRDE_QSIZE_RST;
         cons_n_q <= 16'h0000;
         alo_q <= 32'h00000000;
         ahi_q <= 32'h00000000;
         len_q <= 32'h00000000;
         idfl_q <= 32'h00000000;
         prdata_q <= 32'h00000000;
      end else begin
         clr_q <= wr_ok && hit(paddr, PRDE_OFF_CTRL) && pwdata[PRDE_CTRL_CLR];
         cons_q <= wr_ok && hit(paddr, PRDE_OFF_CONSUME);
         post_q <= post_d;
         if (rd_setup) begin
            prdata_q <= rd_mux;
         end
         if (wr_ok && hit(paddr, PRDE_OFF_CTRL)) en_q <= pwdata[PRDE_CTRL_EN];
         if (wr_ok && hit(paddr, PRDE_OFF_QSIZE)) qsize_q <= pwdata[15:0];
         if (wr_ok && hit(paddr, PRDE_OFF_DADDR_LO)) alo_q <= pwdata;
         if (wr_ok && hit(paddr, PRDE_OFF_DADDR_HI)) ahi_q <= pwdata;
         if (wr_ok && hit(paddr, PRDE_OFF_DLEN)) len_q <= pwdata;
         if (wr_ok && hit(paddr, PRDE_OFF_DIDFL)) idfl_q <= {13'h0000, pwdata[18:0]};
         if (wr_ok && hit(paddr, PRDE_OFF_CONSUME)) cons_n_q <= pwdata[15:0];
      end
   end
endmodule
`default_nettype wire

// *** bench/prde_dev_model.sv ***
// device model: shared ring memory that answers the engine and writes used entries
`timescale 1ns/1ps
`default_nettype none
module prde_dev_model #(
   parameter int QSZ = 4
) (
   // clock
   input wire logic pclk,
   // ring access from the engine
   input wire logic ring_req,
   input wire logic ring_we,
   input wire logic [prde_pkg::PRDE_IDX_W-1:0] ring_slot,
   input wire logic [prde_pkg::PRDE_DESC_W-1:0] ring_wdata,
   output logic ring_ack,
   output logic [prde_pkg::PRDE_DESC_W-1:0] ring_rdata
);
   import prde_pkg::*;
   logic [PRDE_DESC_W-1:0] mem [0:QSZ-1];
   logic dev_wrap = 1'b1;
   int use_idx = 0;
   int delay = 0;
   int cnt = 0;
   initial begin
      ring_ack = 1'b0;
      ring_rdata = '0;
   end
   always @(posedge pclk) begin
      cnt <= 0;
      ring_ack <= 1'b0;
      // released data lines keep toggling
      ring_rdata <= ~ring_rdata;
      if (ring_req && ring_ack) begin
         if (ring_we) mem[ring_slot % QSZ] = ring_wdata;
      end else if (ring_req && cnt >= delay) begin
         ring_ack <= 1'b1;
         ring_rdata <= mem[ring_slot % QSZ];
      end else if (ring_req) begin
         cnt <= cnt + 1;
      end
   end
   // one used entry over the next slot, covering n slots of a group
   task automatic use_next(input logic [15:0] id, input logic wr, input logic [31:0] len,
      input int n);
      logic [15:0] f;
      f = 16'h0000;
      f[PRDE_FL_WRITE] = wr;
      f[PRDE_FL_AVAIL] = dev_wrap;
      f[PRDE_FL_USED] = dev_wrap;
      // entries land in the order the bench completes them, address left zero
      mem[use_idx] = {f, id, len, 64'h0};
      repeat (n) begin
         use_idx = (use_idx + 1) % QSZ;
         if (use_idx == 0) dev_wrap = ~dev_wrap;
      end
   endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench of the packed ring host engine against a device model
`timescale 1ns/1ps
`default_nettype none
module tb;
   import prde_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PRDE_APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ring_req;
   logic ring_we;
   logic [PRDE_IDX_W-1:0] ring_slot;
   logic [PRDE_DESC_W-1:0] ring_wdata;
   logic ring_ack;
   logic [PRDE_DESC_W-1:0] ring_rdata;
   logic avail_notify;
   int n_fail = 0;
   int compares = 0;
   int seed = 32'h561b7150;
   int cycles = 0;
   int notes = 0;
   logic [31:0] rd;
   logic err;
   logic [63:0] pa;
   logic [31:0] pl;
   logic [15:0] pid;
   logic [2:0] pfl;
   logic [15:0] ids [0:3];
   int aidx = 0;
   int uidx = 0;
   logic awrap = 1'b1;
   logic uwrap = 1'b1;
   logic [31:0] qv [0:2] = '{32'h0, 32'h8001, 32'h8000};
   always #5 pclk = ~pclk;
   prde_ring_host i_prde_ring_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ring_req(ring_req), .ring_we(ring_we),
      .ring_slot(ring_slot), .ring_wdata(ring_wdata), .ring_ack(ring_ack),
      .ring_rdata(ring_rdata), .avail_notify(avail_notify));
   prde_dev_model #(.QSZ(4)) i_prde_dev_model (.pclk(pclk), .ring_req(ring_req),
      .ring_we(ring_we), .ring_slot(ring_slot), .ring_wdata(ring_wdata),
      .ring_ack(ring_ack), .ring_rdata(ring_rdata));
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (avail_notify === 1'b1) notes <= notes + 1;
      // every access goes to the slot next in turn
      if ((ring_req & ring_ack) === 1'b1) check(ring_slot, ring_we ? aidx : uidx);
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle so the next call never touches psel in this time step
      @(posedge pclk);
   endtask
   task automatic wait_st(input int b, input logic v);
      int i;
      i = 0;
      do apb(1'b0, PRDE_OFF_STATUS, 32'h0); while (rd[b] !== v && ++i < 60);
   endtask
   task automatic post(input logic [2:0] fl);
      pa = {$random(seed), $random(seed)};
      pl = $random(seed);
      pid = $random(seed);
      pfl = fl;
      apb(1'b1, PRDE_OFF_DADDR_LO, pa[31:0]);
      apb(1'b1, PRDE_OFF_DADDR_HI, pa[63:32]);
      apb(1'b1, PRDE_OFF_DLEN, pl);
      apb(1'b1, PRDE_OFF_DIDFL, {13'h0, fl, pid});
      apb(1'b0, PRDE_OFF_DIDFL, 32'h0);
      check(rd, {13'h0, fl, pid});
      i_prde_dev_model.delay = $random(seed) & 3;
      apb(1'b1, PRDE_OFF_POST, 32'h1);
   endtask
   task automatic landed();
      wait_st(PRDE_ST_BUSY, 1'b0);
      check(i_prde_dev_model.mem[aidx], {~awrap, 7'h0, awrap, 4'h0, pfl,
         pid, pl, pa});
      ids[aidx] = pid;
      aidx = (aidx + 1) % 4;
      if (aidx == 0) awrap = ~awrap;
      apb(1'b0, PRDE_OFF_STATUS, 32'h0);
      check(rd[PRDE_ST_AWRAP], awrap);
   endtask
   task automatic take(input int n, input logic wr);
      logic [31:0] l;
      logic [15:0] id;
      l = $random(seed);
      id = ids[(uidx + n - 1) % 4];
      i_prde_dev_model.delay = $random(seed) & 3;
      i_prde_dev_model.use_next(id, wr, l, n);
      wait_st(PRDE_ST_USED, 1'b1);
      check(rd[PRDE_ST_USED], 1'b1);
      apb(1'b0, PRDE_OFF_USED_ID, 32'h0);
      check(rd, {15'h0, wr, id});
      apb(1'b0, PRDE_OFF_USED_LEN, 32'h0);
      check(rd, wr ? l : 32'h0);
      uidx = (uidx + n) % 4;
      if (uidx < n) uwrap = ~uwrap;
      // a count of zero stands for one slot
      apb(1'b1, PRDE_OFF_CONSUME, n == 1 ? 32'h0 : n);
      repeat (2) @(posedge pclk);
      apb(1'b0, PRDE_OFF_STATUS, 32'h0);
      check({rd[PRDE_ST_UWRAP], rd[PRDE_ST_USED]}, {uwrap, 1'b0});
      $display("test used group of %0d done", n);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, PRDE_OFF_STATUS, 32'h0);
      check(rd, 32'h18);
      apb(1'b0, PRDE_OFF_QSIZE, 32'h0);
      check(rd, 32'h100);
      apb(1'b0, 8'h30, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, PRDE_OFF_QSIZE, qv[i]);
         apb(1'b0, PRDE_OFF_STATUS, 32'h0);
         check(rd[PRDE_ST_QERR], qv[i] == 32'h0 || qv[i] > 32'h8000);
      end
      apb(1'b1, PRDE_OFF_QSIZE, 32'h4);
      apb(1'b1, PRDE_OFF_CTRL, 32'h1);
      $display("test reset and size done");
      for (int i = 0; i < 4; i++) begin
         post(i);
         landed();
      end
      check(rd[PRDE_ST_FULL], 1'b1);
      post(3'h4);
      repeat (20) @(posedge pclk);
      apb(1'b0, PRDE_OFF_STATUS, 32'h0);
      // ring full and nothing used yet: post waits, polled slot not taken as used
      check(rd[2:0], 3'b011);
      $display("test full ring done");
      take(2, 1'b1);
      landed();
      post(3'h5);
      landed();
      take(1, 1'b0);
      take(1, 1'b1);
      take(2, 1'b1);
      post(3'h6);
      landed();
      post(3'h7);
      landed();
      check(notes, 8);
      $display("test wrap and flags done");
      apb(1'b0, PRDE_OFF_INDEX, 32'h0);
      check(rd, {1'b0, uidx[14:0], 1'b0, aidx[14:0]});
      // stop first so no poll is in flight when the restart pulse comes
      apb(1'b1, PRDE_OFF_CTRL, 32'h0);
      repeat (8) @(posedge pclk);
      apb(1'b1, PRDE_OFF_CTRL, 32'h2);
      apb(1'b0, PRDE_OFF_STATUS, 32'h0);
      check(rd, 32'h18);
      apb(1'b0, PRDE_OFF_INDEX, 32'h0);
      check(rd, 32'h0);
      $display("test ring restart done");
      final_report();
   end
endmodule
`default_nettype wire
